// File: core/gpp_pkg.sv
// Package for the general-purpose pin port: offsets, reset values, bus carrier.
package gpp_pkg;
   localparam int unsigned NUM_PINS = 8;
   localparam logic [7:0] DIR_OFFSET = 8'hB4;
   localparam logic [7:0] DATA_OFFSET = 8'hB6;
   localparam logic [7:0] DIAG_OFFSET = 8'hC0;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] OUT_RESET = 8'h00;
   localparam logic [31:0] DIAG_RESET = 32'h0000_0000;
   localparam logic [7:0] UPPER_ZERO = 8'h00;
   localparam logic [7:0] OE_N_RESET = 8'hFF;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
   // Pins that carry a secondary function
   localparam int unsigned PIN_CLOCK_RUN = 0;
   localparam int unsigned PIN_POWER_OVERRIDE = 1;
   localparam int unsigned PIN_SERIAL_CLOCK = 4;
   localparam int unsigned PIN_SERIAL_DATA = 5;

   // Configuration-space access, one dword per cycle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } gpp_cfg_req_t;

   // Per-pin secondary-function selects and their pin drive
   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] out;
      logic [7:0] oe_n;
   } gpp_alt_t;
endpackage : gpp_pkg

// File: core/gpp_port.sv
// General-purpose pin port with direction, data and diagnostic configuration registers.
//
// Contract
// - One direction bit per pin; 0 input at reset, 1 output.
// - Secondary function owns its pin regardless of the direction bit.
// - Pins 0, 1, 4, 5 share clock run, power override, serial clock, data.
// - Upper byte of direction and data registers reads zero, ignores writes.
// - Input pin data bit reads the pin level sampled one edge before the read.
// - Output pin data write changes the driven level.
// - Data writes to input or secondary-function pins are discarded.
// - After reset data low byte shows sampled pins, upper byte zero.
// - Serial-bus enable turns pins 4 and 5 into serial clock and data.
module gpp_port (
   input wire logic sys_clk_i,                 // Configuration clock
   input wire logic rst_n_i,                   // Fundamental reset, sync, active low
   input wire gpp_pkg::gpp_cfg_req_t cfg_req_i, // Configuration access
   output logic [31:0] cfg_rdata_o,             // Read data, valid cycle after rd
   output logic cfg_rvalid_o,                   // Read data valid pulse
   input wire logic clock_run_en_i,             // Pin 0 taken by clock run
   input wire logic power_override_en_i,        // Pin 1 taken by power override
   input wire logic serial_memory_found_i,      // Serial-bus enable, pins 4 and 5
   input wire logic [7:0] alt_out_i,            // Secondary-function output levels
   input wire logic [7:0] alt_oe_n_i,           // Secondary-function enables, low drives
   input wire logic [7:0] pin_i,                // Pin levels
   output logic [7:0] pin_o,                    // Pin drive levels
   output logic [7:0] pin_oe_n_o,               // Pin drive enables, low drives
   output logic [31:0] diag_o                   // Diagnostic register contents
);
   // Register state; each group has one next-value process and one register process, except pin drive, which has one next-value process per pin
   logic [7:0] dir_q;
   logic [7:0] dir_d;
   logic [7:0] out_q;
   logic [7:0] out_d;
   logic [31:0] diag_q;
   logic [31:0] diag_d;
   logic [7:0] pin_val_q;
   logic [7:0] pin_val_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic rvalid_q;
   logic rvalid_d;
   logic [7:0] pin_q;
   logic [7:0] pin_d;
   logic [7:0] oe_n_q;
   logic [7:0] oe_n_d;

   // Decode and takeover helpers
   gpp_pkg::gpp_alt_t alt;
   logic [7:0] gp_out;
   logic [7:0] data_rd;
   logic dir_hit;
   logic data_hit;
   logic diag_hit;
   logic dir_wr;
   logic data_wr;
   logic diag_wr;
   logic pair_rd;
   logic diag_rd;

   always_comb begin
      alt.sel = 8'h00;
      alt.sel[gpp_pkg::PIN_CLOCK_RUN] = clock_run_en_i;
      alt.sel[gpp_pkg::PIN_POWER_OVERRIDE] = power_override_en_i;
      alt.sel[gpp_pkg::PIN_SERIAL_CLOCK] = serial_memory_found_i;
      alt.sel[gpp_pkg::PIN_SERIAL_DATA] = serial_memory_found_i;
      alt.out = alt_out_i;
      alt.oe_n = alt_oe_n_i;
   end

   // Only general-purpose outputs take data writes
   // A write to an input or taken pin leaves its bit as it was
   assign gp_out = dir_q & ~alt.sel;

   // Direction and data share one dword; data sits in bytes 2 and 3
   // Low two address bits are ignored; reads return the whole dword, writes follow the byte enables
   assign dir_hit = cfg_req_i.addr[7:2] == gpp_pkg::DIR_OFFSET[7:2];
   assign data_hit = cfg_req_i.addr[7:2] == gpp_pkg::DATA_OFFSET[7:2];
   assign diag_hit = cfg_req_i.addr[7:2] == gpp_pkg::DIAG_OFFSET[7:2];

   // Lanes 1 and 3 have no storage, so writes there fall away
   // Either offset of the pair reads back the whole dword
   assign dir_wr = cfg_req_i.wr && dir_hit && cfg_req_i.be[0];
   assign data_wr = cfg_req_i.wr && data_hit && cfg_req_i.be[2];
   assign diag_wr = cfg_req_i.wr && diag_hit;
   assign pair_rd = cfg_req_i.rd && (dir_hit || data_hit);
   assign diag_rd = cfg_req_i.rd && diag_hit;

   always_comb begin
      dir_d = dir_q;
      if (dir_wr) begin
         dir_d = cfg_req_i.wdata[7:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         dir_q <= gpp_pkg::DIR_RESET;
      end else begin
         dir_q <= dir_d;
      end
   end

   always_comb begin
      out_d = out_q;
      if (data_wr) begin
         out_d = (cfg_req_i.wdata[23:16] & gp_out) | (out_q & ~gp_out);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         out_q <= gpp_pkg::OUT_RESET;
      end else begin
         out_q <= out_d;
      end
   end

   // Pin levels are taken every edge; a read shows the level one edge old
   always_comb begin
      pin_val_d = pin_i;
   end

   // Sampled through reset too, so the first read shows real pins
   always_ff @(posedge sys_clk_i) begin
      pin_val_q <= pin_val_d;
   end

   // Diagnostic bits are stored as written; their meaning lives elsewhere in the bridge
   always_comb begin
      diag_d = diag_q;
      if (diag_wr) begin
         for (int b = 0; b < 4; b++) begin
            if (cfg_req_i.be[b]) begin
               diag_d[b*8 +: 8] = cfg_req_i.wdata[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         diag_q <= gpp_pkg::DIAG_RESET;
      end else begin
         diag_q <= diag_d;
      end
   end

   // Inputs show pin level, outputs show held value
   assign data_rd = (pin_val_q & ~dir_q) | (out_q & dir_q);

   // Unmapped reads return zero; read data stands for one cycle only
   always_comb begin
      rdata_d = gpp_pkg::RDATA_RESET;
      if (pair_rd) begin
         rdata_d = {gpp_pkg::UPPER_ZERO, data_rd, gpp_pkg::UPPER_ZERO, dir_q};
      end else if (diag_rd) begin
         rdata_d = diag_q;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_q <= gpp_pkg::RDATA_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Every read is answered one edge later, mapped or not
   always_comb begin
      rvalid_d = cfg_req_i.rd;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rvalid_q <= 1'h0;
      end else begin
         rvalid_q <= rvalid_d;
      end
   end

   // Pin drive per pin, from next values so pins move with the register
   generate
      for (genvar p = 0; p < gpp_pkg::NUM_PINS; p++) begin : g_pin
         always_comb begin
            if (alt.sel[p]) begin
               pin_d[p] = alt.out[p];
               oe_n_d[p] = alt.oe_n[p];
            end else begin
               pin_d[p] = out_d[p];
               oe_n_d[p] = ~dir_d[p];
            end
         end
      end
   endgenerate

   // Drivers stay off through reset; taken pins drive from the first edge after release
   // Registered pins cost a cycle of latency but keep the pads free of decode glitches
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pin_q <= gpp_pkg::OUT_RESET;
         oe_n_q <= gpp_pkg::OE_N_RESET;
      end else begin
         pin_q <= pin_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign cfg_rdata_o = rdata_q;
   assign cfg_rvalid_o = rvalid_q;
   assign pin_o = pin_q;
   assign pin_oe_n_o = oe_n_q;
   assign diag_o = diag_q;
endmodule // gpp_port

// File: dv/gpp_pins.sv
// Far-side pin circuitry: outside level wherever the port lets go.
module gpp_pins (
   input wire logic [7:0] drv_i, // Port level
   input wire logic [7:0] oe_n_i, // Port enable, low drives
   input wire logic [7:0] ext_i, // Outside level
   output logic [7:0] lvl_o // Pin level
);
   timeunit 1ns / 1ps;
   assign lvl_o = ~oe_n_i & drv_i | oe_n_i & ext_i;
endmodule // gpp_pins

// File: dv/gpp_chk_props.sv
// Checker on the pin port's ports.
module gpp_chk (
   input wire logic sys_clk_i, // Clock
   input wire logic rst_n_i, // Reset
   input wire gpp_pkg::gpp_cfg_req_t cfg_req_i, // Access
   input wire logic [31:0] cfg_rdata_o, // Data
   input wire logic cfg_rvalid_o, // Valid
   input wire logic clock_run_en_i, // Pin 0
   input wire logic power_override_en_i, // Pin 1
   input wire logic serial_memory_found_i, // Pins 4, 5
   input wire logic [7:0] alt_out_i, // Alt level
   input wire logic [7:0] alt_oe_n_i, // Alt enable
   input wire logic [7:0] pin_i, // Pins
   input wire logic [7:0] pin_o, // Drive
   input wire logic [7:0] pin_oe_n_o // Enable
);
   timeunit 1ns / 1ps;
   wire [7:0] tk = {2'h0, {2{serial_memory_found_i}}, 2'h0, power_override_en_i, clock_run_en_i};
   wire [7:0] wd = cfg_req_i.wdata[23:16];
   wire hit = cfg_req_i.addr[7:2] == 6'h2D;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_rst; !$past(rst_n_i) |-> pin_oe_n_o == 8'hFF && !cfg_rvalid_o; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_up; cfg_rvalid_o && $past(hit) |-> {cfg_rdata_o[31:24], cfg_rdata_o[15:8]} == 16'h0; endproperty
   a_up: assert property (p_up) else $error("upper byte");
   property p_rv; $past(rst_n_i) |-> cfg_rvalid_o == $past(cfg_req_i.rd); endproperty
   a_rv: assert property (p_rv) else $error("read valid");
   property p_in; cfg_rvalid_o && $past(hit) |-> ((cfg_rdata_o[23:16] ^ $past(pin_i, 2)) & ~cfg_rdata_o[7:0]) == 8'h0; endproperty
   a_in: assert property (p_in) else $error("input level");
   property p_alt; $past(rst_n_i) |-> ((pin_o ^ $past(alt_out_i)) & $past(tk)) == 8'h0; endproperty
   a_alt: assert property (p_alt) else $error("alt level");
   property p_low; $past(rst_n_i) |-> ((pin_oe_n_o ^ $past(alt_oe_n_i)) & $past(tk) & 8'h03) == 8'h0; endproperty
   a_low: assert property (p_low) else $error("alt enable");
   property p_ser; $past(rst_n_i) && $past(serial_memory_found_i) |-> ((pin_oe_n_o ^ $past(alt_oe_n_i)) & 8'h30) == 8'h0; endproperty
   a_ser: assert property (p_ser) else $error("serial pins");
   property p_wr; cfg_req_i.wr && hit && cfg_req_i.be[2] |=> ((pin_o ^ $past(wd)) & ~$past(pin_oe_n_o) & ~$past(tk)) == 8'h0; endproperty
   a_wr: assert property (p_wr) else $error("data write");
endmodule // gpp_chk
bind gpp_port gpp_chk u_chk (.*);

// File: dv/test_gpp_port.sv
// Random traffic bench for the pin port against a bench model.
module test_gpp_port;
   timeunit 1ns / 1ps;
   logic sys_clk_i = 1'h0, rst_n_i = 1'h0, clock_run_en_i = 1'h0, power_override_en_i = 1'h0, cfg_rvalid_o;
   logic serial_memory_found_i = 1'h0;
   logic [7:0] alt_out_i = '0, alt_oe_n_i = '0, ext = '0, dir = '0, dat = '0, syn = '0, eoe = 8'hFF, epo = '0, tk;
   logic [7:0] pin_i, pin_o, pin_oe_n_o;
   logic [31:0] cfg_rdata_o, diag_o, ed = '0;
   logic [32:0] erd = '0;
   gpp_pkg::gpp_cfg_req_t cfg_req_i = '0;
   int seed = 30, error_cnt = 0, n_tests = 0, op;
   always #2.5 sys_clk_i = ~sys_clk_i;
   gpp_port DUT (.*);
   gpp_pins P (.drv_i(pin_o), .oe_n_i(pin_oe_n_o), .ext_i(ext), .lvl_o(pin_i));
   task chk(input logic [80:0] s, e);
      n_tests++;
      error_cnt += s !== e;
      if (s !== e) $display("[ERR] %0t got %h exp %h", $time, s, e);
   endtask
   task end_of_test;
      $display("random test done, %0d errors in %0d compares", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #16000 error_cnt++;
      end_of_test;
   end
   initial begin
      ext = 8'($random(seed));
      syn = ext;
      #40 rst_n_i = 1'h1;
      for (int i = 0; i < 3000; i++) begin
         chk({cfg_rvalid_o, cfg_rdata_o, diag_o, pin_oe_n_o, pin_o & ~eoe}, {erd, ed, eoe, epo & ~eoe});
         op = i < 2 ? 2 + i : {$random(seed)} % 8;
         {ext, alt_out_i, alt_oe_n_i} = 24'($random(seed));
         cfg_req_i = '{op < 2 || op == 4, op inside {2, 3, 5, 6}, op < 4 ? {6'h2D, op[0], 1'h0} : op < 6 ? 8'hC0 : 8'h10,
            4'h1 << ext[1:0], $random(seed)};
         // Takeovers move only on reads, so no write meets a pin whose owner just changed
         if (cfg_req_i.rd) {clock_run_en_i, power_override_en_i, serial_memory_found_i} = 3'($random(seed));
         tk = {2'h0, {2{serial_memory_found_i}}, 2'h0, power_override_en_i, clock_run_en_i};
         erd = {cfg_req_i.rd, !cfg_req_i.rd ? 32'h0 : op < 4 ? {8'h00, dir & dat | ~dir & syn, 8'h00, dir} : op == 5 ? ed : 32'h0};
         syn = ~eoe & epo | eoe & ext;
         if (op < 2 && cfg_req_i.be[2]) dat = dat & ~(dir & ~tk) | cfg_req_i.wdata[23:16] & dir & ~tk;
         if (op < 2 && cfg_req_i.be[0]) dir = cfg_req_i.wdata[7:0];
         for (int b = 0; b < 4; b++) if (op == 4 && cfg_req_i.be[b]) ed[8*b+:8] = cfg_req_i.wdata[8*b+:8];
         {eoe, epo} = {tk & alt_oe_n_i | ~tk & ~dir, tk & alt_out_i | ~tk & dat};
         #5;
      end
      chk({cfg_rvalid_o, cfg_rdata_o, diag_o, pin_oe_n_o, pin_o & ~eoe}, {erd, ed, eoe, epo & ~eoe});
      cfg_req_i = '{1'h1, 1'h0, gpp_pkg::DIAG_OFFSET, 4'hF, 32'h0000_0000};
      #5 cfg_req_i = '0;
      #5 chk({49'h0, diag_o}, 81'h0);
      $display("random traffic test done");
      end_of_test;
   end
endmodule // test_gpp_port
